//--- rcd_pkg.sv
// constants, types and register map of the reset cause dispatcher
package rcd_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int TIMEOUT_S = 4; // override, ack, power good
  localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int HOLD_NS = 1000; // reset pulse width, least time
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRCYC_US = 100; // power-off period, least time
  localparam int PWRCYC_CYC = PWRCYC_US * CLK_MHZ;
  localparam int TW = 28; // timer width, holds TIMEOUT_CYC
  // ==========================================================
  // register map, byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_CFG = 8'h04;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h08;
  localparam int CTRL_FULL_BIT = 3;
  localparam int CTRL_GLOBAL_BIT = 4;
  localparam int CFG_ESC_BIT = 0;
  localparam int CFG_DEEP_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam int STAT_OUT_LSB = 4;
  localparam int STAT_DEEP_BIT = 8;
  // ==========================================================
  // sleep state encoding
  localparam logic [1:0] SLP_S0 = 2'h0;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_WARN = 4'b0001, ST_PLT = 4'b0010,
    ST_GLOBAL = 4'b0011, ST_OFF = 4'b0100, ST_WAKE = 4'b0101,
    ST_S5 = 4'b0110, ST_DEEP = 4'b0111, ST_UP = 4'b1000
  } rcd_state_e;
  typedef enum logic [2:0] {
    OUT_NONE = 3'b000, OUT_HOST = 3'b001, OUT_HOST_PC = 3'b010,
    OUT_GLOBAL = 3'b011, OUT_S5 = 3'b100
  } rcd_outcome_e;
endpackage

//--- rcd_timer.sv
// cycle timer with clear, run and a variable limit
module rcd_timer
  import rcd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [rcd_pkg::TW-1:0] limit_i,
  output logic done_o
);
  logic [TW-1:0] count;

  // count up while running, stop at the limit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (clear_i || !run_i) begin
      count <= '0;
    end else if (!done_o) begin
      count <= count + 1'b1;
    end
  end

  assign done_o = run_i && (count >= limit_i);
endmodule // rcd_timer

//--- rcd_dispatch.sv
// reset cause dispatcher: trigger classification and reset sequencing
// Behaviour
// - power button held four seconds sends platform to S5 and keeps it there until a wake event
// - processor shutdown cycle with global bit set gives global reset
// - shutdown cycle, global clear, full-reset bit set: power-cycled host reset
// - shutdown cycle, global clear, full-reset bit clear: plain host reset
// - controller host resets map to plain, power-cycled, or power-down resets
// - controller power button override goes straight to S5
// - watchdogs and controller uncorrectable error go straight to S5
// - with escalation enabled and S0 involved, those give global reset
// - controller global reset request gives global reset with power cycle
// - processor power good timeout gives global reset
// - plain host reset requests are dropped in S3, S4 or S5
// - power-cycled host reset in software sleep skips the warning
// - global reset sends no warning and starts at once
// - missing processor acknowledge escalates host reset to global reset
// - power-down host reset holds power off until a wake event
// - S5 continues into deep sleep when enabled and conditions hold
// - warning sent, processor acknowledges, then platform reset asserts
// - acknowledge wait is bounded by the timeout, then global reset
// - global reset resets all but this suspend logic and its registers
module rcd_dispatch
  import rcd_pkg::*;
#(
  parameter logic [rcd_pkg::TW-1:0] TIMEOUT_CYCLES = rcd_pkg::TW'(rcd_pkg::TIMEOUT_CYC),
  parameter logic [rcd_pkg::TW-1:0] PWRCYC_CYCLES = rcd_pkg::TW'(rcd_pkg::PWRCYC_CYC)
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rcd_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // triggers
  input wire logic pwr_btn_i,
  input wire logic shutdown_cycle_i,
  input wire logic mc_host_reset_i,
  input wire logic mc_host_reset_pc_i,
  input wire logic mc_host_reset_pd_i,
  input wire logic mc_pwr_btn_ovr_i,
  input wire logic mc_global_reset_i,
  input wire logic mc_watchdog_i,
  input wire logic pm_watchdog_i,
  input wire logic mc_uncorr_err_i,
  // platform state and processor
  input wire logic [1:0] sleep_state_i,
  input wire logic sleep_sw_entered_i,
  input wire logic dest_state_s0_i,
  input wire logic wake_event_i,
  input wire logic deep_sleep_ok_i,
  input wire logic reset_ack_i,
  input wire logic cpu_power_good_i,
  output logic reset_warn_o,
  output logic platform_reset_out_n_o,
  output logic global_reset_o,
  output logic power_on_o,
  output logic deep_sleep_state_o
);
  import rcd_pkg::*;

  rcd_state_e state, next_state;
  rcd_outcome_e last_out, next_out, win;
  logic pc_q, next_pc, pd_q, next_pd;
  logic [7:0] reset_control_reg;
  logic [1:0] cfg;
  logic seq_done, pbo_done;
  logic [TW-1:0] seq_limit;

  // ==========================================================
  // register bus
  // ack one cycle after request, data latched with it
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire sel_ctrl = (wb_adr_i == ADDR_CTRL);
  wire sel_cfg = (wb_adr_i == ADDR_CFG);
  wire sel_stat = (wb_adr_i == ADDR_STATUS);
  wire [31:0] stat_word = {23'h00_0000, deep_sleep_state_o, 1'b0,
                           last_out, state};
  wire [31:0] rd_word = sel_ctrl ? {24'h00_0000, reset_control_reg} :
                        sel_cfg ? {30'h0000_0000, cfg} :
                        sel_stat ? stat_word : 32'h0000_0000;

  // bus answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // control registers, kept through global reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_control_reg <= CTRL_RST;
      cfg <= CFG_RST;
    end else if (wr && sel_ctrl) begin
      reset_control_reg <= wb_dat_i[7:0];
    end else if (wr && sel_cfg) begin
      cfg <= wb_dat_i[1:0];
    end
  end

  // ==========================================================
  // trigger classification
  wire gbit = reset_control_reg[CTRL_GLOBAL_BIT];
  wire fbit = reset_control_reg[CTRL_FULL_BIT];
  wire esc_en = cfg[CFG_ESC_BIT];
  wire deep_en = cfg[CFG_DEEP_BIT];
  wire in_sleep = (sleep_state_i != SLP_S0);
  wire any_wdt = mc_watchdog_i || pm_watchdog_i || mc_uncorr_err_i;
  wire esc = esc_en && (!in_sleep || dest_state_s0_i);
  wire req_s5 = pbo_done || mc_pwr_btn_ovr_i || (any_wdt && !esc);
  wire req_glob = (shutdown_cycle_i && gbit) || mc_global_reset_i
                  || (any_wdt && esc);
  wire req_pd = mc_host_reset_pd_i;
  wire req_pc = (shutdown_cycle_i && !gbit && fbit) || mc_host_reset_pc_i
                || req_pd;
  wire raw_np = (shutdown_cycle_i && !gbit && !fbit) || mc_host_reset_i;
  wire req_np = raw_np && !in_sleep;
  wire skip_warn = in_sleep && sleep_sw_entered_i;

  // most severe pending outcome wins
  always_comb begin
    if (req_s5) begin
      win = OUT_S5;
    end else if (req_glob) begin
      win = OUT_GLOBAL;
    end else if (req_pc) begin
      win = OUT_HOST_PC;
    end else if (req_np) begin
      win = OUT_HOST;
    end else begin
      win = OUT_NONE;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    next_out = last_out;
    next_pc = pc_q;
    next_pd = pd_q;
    case (state)
      ST_IDLE: begin
        next_out = (win == OUT_NONE) ? last_out : win;
        case (win)
          OUT_S5: next_state = ST_S5;
          OUT_GLOBAL: begin
            next_state = ST_GLOBAL;
            next_pd = 1'b0;
          end
          OUT_HOST_PC: begin
            next_state = skip_warn ? ST_PLT : ST_WARN;
            next_pc = 1'b1;
            next_pd = req_pd;
          end
          OUT_HOST: begin
            next_state = ST_WARN;
            next_pc = 1'b0;
            next_pd = 1'b0;
          end
          default: next_state = ST_IDLE;
        endcase
      end
      ST_WARN: begin
        if (reset_ack_i) begin
          next_state = ST_PLT;
        end else if (seq_done) begin
          next_state = ST_GLOBAL;
          next_out = OUT_GLOBAL;
          next_pd = 1'b0;
        end
      end
      ST_PLT: begin
        if (seq_done) begin
          next_state = pc_q ? ST_OFF : ST_UP;
        end
      end
      ST_GLOBAL: begin
        if (seq_done) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (seq_done) begin
          next_state = pd_q ? ST_WAKE : ST_UP;
        end
      end
      ST_WAKE: begin
        if (wake_event_i) begin
          next_state = ST_UP;
        end
      end
      ST_S5: begin
        if (deep_en && deep_sleep_ok_i) begin
          next_state = ST_DEEP;
        end else if (wake_event_i) begin
          next_state = ST_UP;
        end
      end
      ST_DEEP: begin
        if (wake_event_i) begin
          next_state = ST_UP;
        end
      end
      ST_UP: begin
        if (cpu_power_good_i) begin
          next_state = ST_IDLE;
        end else if (seq_done) begin
          next_state = ST_GLOBAL;
          next_out = OUT_GLOBAL;
          next_pd = 1'b0;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      last_out <= OUT_NONE;
      pc_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      state <= next_state;
      last_out <= next_out;
      pc_q <= next_pc;
      pd_q <= next_pd;
    end
  end

  // ==========================================================
  // timers: one shared by the warn, platform reset, global, power-off and power-up steps, one for the power button
  wire seq_run = (state == ST_WARN) || (state == ST_PLT) || (state == ST_GLOBAL)
                 || (state == ST_OFF) || (state == ST_UP);
  assign seq_limit = ((state == ST_PLT) || (state == ST_GLOBAL)) ? TW'(HOLD_CYC) :
                     (state == ST_OFF) ? PWRCYC_CYCLES : TIMEOUT_CYCLES;

  rcd_timer u_seq_tmr (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(next_state != state),
    .run_i(seq_run),
    .limit_i(seq_limit),
    .done_o(seq_done)
  );

  rcd_timer u_pbo_tmr (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(!pwr_btn_i),
    .run_i(pwr_btn_i && (state == ST_IDLE)),
    .limit_i(TIMEOUT_CYCLES),
    .done_o(pbo_done)
  );

  // ==========================================================
  // outputs decoded from state
  assign reset_warn_o = (state == ST_WARN);
  assign platform_reset_out_n_o = (state == ST_IDLE) || (state == ST_WARN);
  assign global_reset_o = (state == ST_GLOBAL);
  assign power_on_o = !((state == ST_OFF) || (state == ST_WAKE)
                        || (state == ST_S5) || (state == ST_DEEP));
  assign deep_sleep_state_o = (state == ST_DEEP);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  wire idle = (state == ST_IDLE);
  sequence s_warn_acked;
    (state == ST_WARN) && reset_ack_i;
  endsequence
  sequence s_plt_low;
    (state == ST_PLT) && !platform_reset_out_n_o && !reset_warn_o;
  endsequence
  sequence s_held_off;
    (state == ST_WAKE) && !power_on_o && !platform_reset_out_n_o;
  endsequence

  warn_ack_a: assert property (s_warn_acked |=> s_plt_low)
    else $error("ack did not start platform reset");
  ack_timeout_a: assert property ((state == ST_WARN) && seq_done && !reset_ack_i
    |=> global_reset_o && !reset_warn_o && (last_out == OUT_GLOBAL))
    else $error("missing ack did not escalate");
  global_now_a: assert property (idle && req_glob && !req_s5
    |=> global_reset_o && !reset_warn_o)
    else $error("global reset was delayed or warned");
  shut_global_a: assert property (idle && shutdown_cycle_i && gbit && !req_s5
    |=> (state == ST_GLOBAL))
    else $error("shutdown with global bit not global");
  full_bit_a: assert property (idle && shutdown_cycle_i && !gbit && fbit && !req_s5
    && !req_glob |=> pc_q && (last_out == OUT_HOST_PC))
    else $error("full reset bit ignored");
  np_drop_a: assert property (idle && in_sleep && !req_s5 && !req_glob && !req_pc
    |=> idle && platform_reset_out_n_o)
    else $error("host reset taken in sleep");
  sw_skip_a: assert property (idle && (win == OUT_HOST_PC) && skip_warn
    |=> (state == ST_PLT) ##1 !reset_warn_o)
    else $error("warning sent in software sleep");
  escalate_a: assert property (idle && any_wdt && esc
    && !pbo_done && !mc_pwr_btn_ovr_i |=> global_reset_o)
    else $error("watchdog not escalated");
  s5_stay_a: assert property ((state == ST_S5) && !wake_event_i && !deep_en
    |=> (state == ST_S5) && !power_on_o && !platform_reset_out_n_o)
    else $error("left S5 without wake");
  wake_hold_a: assert property ((state == ST_WAKE) && !wake_event_i
    |=> s_held_off)
    else $error("power restored before wake");
  deep_entry_a: assert property ((state == ST_S5) && deep_en && deep_sleep_ok_i
    |=> deep_sleep_state_o)
    else $error("deep sleep not entered");
  pg_stuck_a: assert property ((state == ST_UP) && seq_done && !cpu_power_good_i
    |=> (state == ST_GLOBAL) ##1 !platform_reset_out_n_o)
    else $error("stuck power good not escalated");
  severity_a: assert property (idle && req_s5 |=> (state == ST_S5) && !global_reset_o)
    else $error("lower outcome won over S5");
  host_warn_a: assert property (idle && (win == OUT_HOST)
    |=> reset_warn_o && platform_reset_out_n_o && !pc_q)
    else $error("plain host reset did not warn");
  pd_off_a: assert property ((state == ST_OFF) && seq_done && pd_q
    |=> s_held_off)
    else $error("power-down reset did not wait for wake");
  pg_up_a: assert property ((state == ST_UP) && cpu_power_good_i
    |=> idle && platform_reset_out_n_o)
    else $error("power good did not end the reset");
  ctrl_keep_a: assert property (global_reset_o && !wb_ack_o
    |=> $stable(reset_control_reg) && $stable(cfg))
    else $error("global reset disturbed control registers");
endmodule // rcd_dispatch

//--- rcd_cpu_model.sv
// processor model: answers the reset warning and reports power good
module rcd_cpu_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reset_warn_i,
  input wire logic platform_reset_out_n_i,
  input wire logic power_on_i,
  input wire logic ack_en_i,
  input wire logic pg_en_i,
  output logic reset_ack_o,
  output logic cpu_power_good_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int warn_cnt;
  int pg_cnt;
  // ==========================================================
  // handshake and power good
  // ack only after a few cycles of warning, dropped once warning goes
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      warn_cnt <= 0;
      pg_cnt <= 0;
      reset_ack_o <= 1'h0;
      cpu_power_good_o <= 1'h1;
    end else begin
      warn_cnt <= reset_warn_i ? warn_cnt + 1 : 0;
      reset_ack_o <= ack_en_i && reset_warn_i && warn_cnt >= 3;
      pg_cnt <= (power_on_i && !platform_reset_out_n_i) ? pg_cnt + 1 : 0;
      cpu_power_good_o <= pg_en_i && (platform_reset_out_n_i || pg_cnt >= 8); // power good late
    end
  end
endmodule // rcd_cpu_model

//--- test_reset_cause_dispatcher.sv
// self-checking bench for the reset cause dispatcher
module test_reset_cause_dispatcher import rcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, cyc, stb, we, ack, sw, ds0, wake, dok, ack_en, pg_en, r_ack, pg;
  logic warn, plat_n, glob, pwr_on, deep, dp;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [9:0] tr;
  logic [1:0] slp;
  int errors, check_count, cycles;
  // ==========================================================
  // design with short timeout and power-off period, and processor
  rcd_dispatch #(.TIMEOUT_CYCLES(TW'(40)), .PWRCYC_CYCLES(TW'(10))) u_dut (
    .clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pwr_btn_i(tr[0]), .shutdown_cycle_i(tr[1]), .mc_host_reset_i(tr[2]),
    .mc_host_reset_pc_i(tr[3]), .mc_host_reset_pd_i(tr[4]), .mc_pwr_btn_ovr_i(tr[5]),
    .mc_global_reset_i(tr[6]), .mc_watchdog_i(tr[7]), .pm_watchdog_i(tr[8]),
    .mc_uncorr_err_i(tr[9]), .sleep_state_i(slp), .sleep_sw_entered_i(sw),
    .dest_state_s0_i(ds0), .wake_event_i(wake), .deep_sleep_ok_i(dok), .reset_ack_i(r_ack),
    .cpu_power_good_i(pg), .reset_warn_o(warn), .platform_reset_out_n_o(plat_n),
    .global_reset_o(glob), .power_on_o(pwr_on), .deep_sleep_state_o(deep)
  );
  rcd_cpu_model u_cpu (
    .clk_i(clk), .reset_n_i(rst_n), .reset_warn_i(warn), .platform_reset_out_n_i(plat_n),
    .power_on_i(pwr_on), .ack_en_i(ack_en), .pg_en_i(pg_en), .reset_ack_o(r_ack),
    .cpu_power_good_o(pg)
  );
  // ==========================================================
  // clock and hang guard
  always #10 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic fire(input logic [9:0] t, input int n);
    @(posedge clk);
    tr <= t;
    repeat (n) @(posedge clk);
    tr <= 10'h000;
    #1;
  endtask
  // returns at a clock edge once the sequence is back in idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (!(plat_n === 1'h1 && warn === 1'h0 && pwr_on === 1'h1 && glob === 1'h0)
           && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n < 600), 32'h0000_0001);
    @(posedge clk);
  endtask
  task automatic run(input logic [9:0] t, input rcd_outcome_e ex, input int n, input logic wk);
    logic [31:0] q;
    fire(t, n);
    if (ex == OUT_S5) check(32'({pwr_on, plat_n}), 32'h0000_0000);
    else if (ex == OUT_GLOBAL) check(32'({glob, warn}), 32'h0000_0002);
    else check(32'(warn), 32'h0000_0001);
    if (wk) begin
      repeat (100) @(posedge clk);
      check(32'({pwr_on, plat_n, deep}), 32'(dp));
      wake <= 1'h1;
    end
    wait_idle();
    wake <= 1'h0;
    wb(1'h0, ADDR_STATUS, 4'hf, 32'h0000_0000, q);
    check(32'(q[6:4]), 32'(ex));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] a [4] = '{ADDR_CTRL, ADDR_CFG, ADDR_STATUS, 8'h0c};
    logic [31:0] q;
    wb(1'h1, ADDR_CTRL, 4'he, 32'h0000_0018, q);
    wb(1'h1, 8'h0c, 4'hf, 32'hffff_ffff, q);
    foreach (a[i]) begin
      wb(1'h0, a[i], 4'hf, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
    end
    $display("test registers done");
  endtask
  task automatic t_shutdown();
    logic [7:0] v [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
    rcd_outcome_e e [4] = '{OUT_HOST, OUT_HOST_PC, OUT_GLOBAL, OUT_GLOBAL};
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, ADDR_CTRL, 4'hf, 32'(v[i]), q);
      run(10'h002, e[i], 1, 1'h0);
      wb(1'h0, ADDR_CTRL, 4'hf, 32'h0000_0000, q);
      check(q, 32'(v[i]));
    end
    wb(1'h1, ADDR_CTRL, 4'hf, 32'h0000_0000, q);
    $display("test shutdown done");
  endtask
  task automatic t_table();
    logic [9:0] t [11] = '{10'h004, 10'h008, 10'h040, 10'h020, 10'h080, 10'h100, 10'h200,
      10'h010, 10'h084, 10'h048, 10'h001};
    rcd_outcome_e e [11] = '{OUT_HOST, OUT_HOST_PC, OUT_GLOBAL, OUT_S5, OUT_S5, OUT_S5,
      OUT_S5, OUT_HOST_PC, OUT_S5, OUT_GLOBAL, OUT_S5};
    for (int i = 0; i < 11; i++) begin
      run(t[i], e[i], (i == 10) ? 45 : 1, e[i] == OUT_S5 || i == 7);
    end
    $display("test trigger table done");
  endtask
  task automatic t_cfg();
    logic [31:0] q;
    wb(1'h1, ADDR_CFG, 4'hf, 32'h0000_0001, q);
    for (int i = 7; i < 10; i++) run(10'(1 << i), OUT_GLOBAL, 1, 1'h0);
    slp <= 2'h3;
    ds0 <= 1'h1;
    run(10'h100, OUT_GLOBAL, 1, 1'h0);
    ds0 <= 1'h0;
    run(10'h200, OUT_S5, 1, 1'h1);
    slp <= 2'h0;
    ds0 <= 1'h0;
    wb(1'h1, ADDR_CFG, 4'hf, 32'h0000_0002, q);
    dok <= 1'h1;
    dp = 1'h1;
    run(10'h020, OUT_S5, 1, 1'h1);
    dok <= 1'h0;
    dp = 1'h0;
    wb(1'h1, ADDR_CFG, 4'hf, 32'h0000_0000, q);
    $display("test configuration done");
  endtask
  task automatic t_sleep();
    logic [31:0] q;
    @(posedge clk);
    slp <= 2'h3;
    fire(10'h004, 1);
    repeat (5) @(posedge clk);
    #1;
    check(32'({warn, plat_n, pwr_on}), 32'h0000_0003);
    fire(10'h008, 1);
    check(32'(warn), 32'h0000_0001);
    wait_idle();
    @(posedge clk);
    sw <= 1'h1;
    fire(10'h008, 1);
    check(32'({warn, plat_n}), 32'h0000_0000);
    wait_idle();
    slp <= 2'h0;
    sw <= 1'h0;
    wb(1'h0, ADDR_STATUS, 4'hf, 32'h0000_0000, q);
    check(32'(q[6:4]), 32'(OUT_HOST_PC));
    $display("test sleep states done");
  endtask
  // processor withholds ack or power good, cycles counted to global reset
  task automatic t_stall(input logic a, input logic p, input int lo, input int hi);
    int n;
    logic [31:0] q;
    @(posedge clk);
    ack_en <= a;
    pg_en <= p;
    fire(10'h004, 1);
    n = 0;
    while (glob !== 1'h1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n >= lo && n <= hi), 32'h0000_0001);
    @(posedge clk);
    ack_en <= 1'h1;
    pg_en <= 1'h1;
    wait_idle();
    wb(1'h0, ADDR_STATUS, 4'hf, 32'h0000_0000, q);
    check(32'(q[6:4]), 32'(OUT_GLOBAL));
    $display("test stalled processor done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    {cyc, stb, we, sw, ds0, wake, dok, dp} = 8'h00;
    {ack_en, pg_en} = 2'h3;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    tr = 10'h000;
    slp = 2'h0;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_shutdown();
    t_table();
    t_cfg();
    t_sleep();
    t_stall(1'h0, 1'h1, 38, 46);
    t_stall(1'h1, 1'h0, 90, 110);
    end_sim();
  end
endmodule // test_reset_cause_dispatcher
